// File: rcs_pkg.sv
package rcs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int REF_PERIOD_NS    = 40;    // slowest reference period expected
  localparam int LOSS_REF_PERIODS = 2;
  localparam int REQ_MIN_REF_CYC  = 3;
  localparam int SWITCH_DELAY_CYC = 0;
  localparam int RESET_HOLD_NS    = 10;
  localparam int CNT_W            = 8;
  localparam int HCNT_W           = 16;
  // loss limit rounds up: a stall must last the full two periods
  localparam logic [CNT_W-1:0]  LOSS_CNT = CNT_W'((LOSS_REF_PERIODS * REF_PERIOD_NS + CLK_PERIOD_NS - 1)
                                                  / CLK_PERIOD_NS);
  // request hold: one spare reference period plus synchroniser margin
  localparam int                REQ_HOLD_CYC    = ((REQ_MIN_REF_CYC + SWITCH_DELAY_CYC + 1) * REF_PERIOD_NS)
                                                  / CLK_PERIOD_NS + 4;
  localparam int                RESET_HOLD_CYC  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int                LOCK_STABLE_CYC = 16;

  // ****************************************
  // modes and states
  // ****************************************
  typedef enum logic [1:0] {
    RCS_AUTO     = 2'h0,
    RCS_MANUAL   = 2'h1,
    RCS_OVERRIDE = 2'h2
  } rcs_mode_type;

  typedef enum logic [3:0] {
    SW_IDLE = 4'h1,
    SW_GATE = 4'h2,
    SW_MUX  = 4'h4,
    SW_DONE = 4'h8
  } rcs_sw_state_type;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_REQ  = 4'h2,
    H_RST  = 4'h4,
    H_LOCK = 4'h8
  } rcs_host_state_type;

  // ****************************************
  // host registers
  // ****************************************
  localparam logic [3:0] CTRL_OFS     = 4'h0;
  localparam logic [3:0] STAT_OFS     = 4'h4;
  localparam int         CTRL_GO_BIT  = 0;
  localparam int         STAT_LOSS0   = 0;
  localparam int         STAT_LOSS1   = 1;
  localparam int         STAT_ACTIVE  = 2;
  localparam int         STAT_BUSY    = 3;
  localparam int         STAT_OUT_EN  = 4;

  // ****************************************
  // state records
  // ****************************************
  typedef struct packed {
    logic [1:0]            ref_m;
    logic [1:0]            ref_s;
    logic [1:0]            ref_p;
    logic                  req_m;
    logic                  req_s;
    logic                  req_p;
    logic                  lock_m;
    logic                  lock_s;
    logic [1:0][CNT_W-1:0] idle_cnt;
    logic [1:0]            loss;
    logic                  armed;
    logic [CNT_W-1:0]      hold_cnt;
    logic                  pend;
    logic                  sel;
    logic                  gated;
    logic                  active;
    logic                  ref_out;
    logic                  loop_rst;
    rcs_sw_state_type      st;
  } rcs_dev_state_type;

  typedef struct packed {
    rcs_host_state_type    st;
    logic [HCNT_W-1:0]     cnt;
    logic                  req;
    logic                  rst;
    logic                  oen;
    logic                  wait_r;
    logic [31:0]           rdata;
  } rcs_host_state_type_rec_type;

  localparam rcs_dev_state_type           DEV_RST  = '{st: SW_IDLE, default: '0};
  localparam rcs_host_state_type_rec_type HOST_RST = '{st: H_LOCK, wait_r: 1'b1, default: '0};

endpackage : rcs_pkg

// File: rcs_link_if.sv
interface rcs_link_if;
  logic switch_req;
  logic loop_reset;
  logic loss_primary;
  logic loss_backup;
  logic active_sel;
  logic pll_locked;

  modport dev (
    input  switch_req,
    input  loop_reset,
    output loss_primary,
    output loss_backup,
    output active_sel,
    output pll_locked
  );

  modport host (
    output switch_req,
    output loop_reset,
    input  loss_primary,
    input  loss_backup,
    input  active_sel,
    input  pll_locked
  );
endinterface : rcs_link_if

// File: rcs_dev.sv
// Contract
// R1: auto, manual and override modes supported
// R2: auto mode moves to backup on loss
// R3: request rise held three cycles swaps input
// R4: override: high request blocks automatic switching
// R5: loss flag per stalled input
// R6: active indicator shows input in use
// R7: automatic switching repeats without limit
// R8: no switch when other input dead
// R9: loss after about two stalled periods
// R10: host switches manually for wide frequency gaps
// R11: gate on old fall, mux on new fall
// R12: override: indicator follows request, no loss
// R13: only request rising edge switches
// R14: wait until target input toggles
// R15: primary input selected by default
// R16: host lowers request before next switch
// R17: host holds request three slower cycles
// R18: request hold includes configured delay cycles
// R19: system keeps inputs running and close
// R20: host resets loop around a switchover
// R21: loss flags and indicator exported
// R22: host holds reset, waits stable lock
// R23: request synchronised before edge and counting
module rcs_dev
  import rcs_pkg::*;
#(
  parameter int SWITCH_DELAY = SWITCH_DELAY_CYC
) (
  input  wire logic   CLOCK,
  input  wire logic   RST_N,
  rcs_link_if.dev     LINK,
  input  wire logic   REF_CLOCK_PRIMARY,
  input  wire logic   REF_CLOCK_BACKUP,
  input  wire logic   PLL_LOCKED,
  input  rcs_mode_type MODE,
  output logic        REF_OUT,
  output logic        LOOP_RESET
);

  // ****************************************
  // constants and state
  // ****************************************
  localparam logic [CNT_W-1:0] HOLD_NEED = CNT_W'(REQ_MIN_REF_CYC + SWITCH_DELAY);

  rcs_dev_state_type st_ff;
  rcs_dev_state_type nxt_st;
  logic [1:0]        edge_any;
  logic [1:0]        fall;
  logic [1:0]        rise;
  logic              cur;
  logic              oth;
  logic              man_trig;
  logic              auto_trig;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st   = st_ff;
    edge_any = st_ff.ref_s ^ st_ff.ref_p;
    fall     = st_ff.ref_p & ~st_ff.ref_s;
    rise     = st_ff.ref_s & ~st_ff.ref_p;
    cur      = st_ff.sel;
    oth      = ~st_ff.sel;

    // two-flop capture of pins from other domains
    nxt_st.ref_m  = {REF_CLOCK_BACKUP, REF_CLOCK_PRIMARY};
    nxt_st.ref_s  = st_ff.ref_m;
    nxt_st.ref_p  = st_ff.ref_s;
    nxt_st.req_m  = LINK.switch_req;                              // see R23
    nxt_st.req_s  = st_ff.req_m;
    nxt_st.req_p  = st_ff.req_s;
    nxt_st.lock_m = PLL_LOCKED;
    nxt_st.lock_s = st_ff.lock_m;

    // clock sense: any edge restarts the stall count
    for (int i = 0; i < 2; i++) begin
      if (edge_any[i]) begin
        nxt_st.idle_cnt[i] = '0;
        nxt_st.loss[i]     = 1'b0;
      end else if (st_ff.idle_cnt[i] >= LOSS_CNT - 1'b1) begin
        nxt_st.loss[i]     = 1'b1;                                // see R5, R9
      end else begin
        nxt_st.idle_cnt[i] = st_ff.idle_cnt[i] + 1'b1;
      end
    end

    // request qualifier: armed only by a rising edge
    if (!st_ff.req_s) begin
      nxt_st.armed = 1'b0;
    end else if (!st_ff.req_p) begin
      nxt_st.armed    = 1'b1;                                     // see R13, R16
      nxt_st.hold_cnt = '0;
    end else if (st_ff.armed && rise[cur]) begin
      nxt_st.hold_cnt = st_ff.hold_cnt + 1'b1;                    // see R3, R18
    end

    // manual trigger after enough reference cycles held high
    man_trig = st_ff.armed && st_ff.req_s && (st_ff.hold_cnt >= HOLD_NEED)
               && (MODE != RCS_AUTO) && (st_ff.st == SW_IDLE) && !st_ff.pend;   // see R1, R3, R12
    // automatic trigger only when the other input is alive
    auto_trig = ((MODE == RCS_AUTO) || ((MODE == RCS_OVERRIDE) && !st_ff.req_s))   // see R1, R4
                && st_ff.loss[cur] && !st_ff.loss[oth]                             // see R2, R7, R8
                && (st_ff.st == SW_IDLE) && !st_ff.pend;
    if (man_trig) begin
      nxt_st.pend  = 1'b1;
      nxt_st.armed = 1'b0;
    end else if (auto_trig) begin
      nxt_st.pend = 1'b1;
    end

    // glitch-free handover sequence
    case (st_ff.st)
      SW_IDLE: begin
        if (st_ff.pend && !st_ff.loss[oth]) begin                 // see R14
          nxt_st.pend = 1'b0;
          nxt_st.st   = SW_GATE;
        end
      end
      SW_GATE: begin
        // a dead old input never falls, so its loss also gates
        if (fall[cur] || st_ff.loss[cur]) begin
          nxt_st.gated = 1'b1;                                    // see R11
          nxt_st.st    = SW_MUX;
        end
      end
      SW_MUX: begin
        if (fall[oth]) begin
          nxt_st.sel   = oth;                                     // see R11, R14
          nxt_st.gated = 1'b0;
          nxt_st.st    = SW_DONE;
        end
      end
      SW_DONE: begin
        nxt_st.active = st_ff.sel;                                // see R6, R11
        nxt_st.st     = SW_IDLE;
      end
      default: begin
        nxt_st.st = SW_IDLE;
      end
    endcase

    // registered reference, low while gated
    nxt_st.ref_out  = st_ff.gated ? 1'b0 : st_ff.ref_s[st_ff.sel];
    nxt_st.loop_rst = LINK.loop_reset;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= DEV_RST;                                           // see R15
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign REF_OUT           = st_ff.ref_out;
  assign LOOP_RESET        = st_ff.loop_rst;
  assign LINK.loss_primary = st_ff.loss[0];                       // see R21
  assign LINK.loss_backup  = st_ff.loss[1];
  assign LINK.active_sel   = st_ff.active;
  assign LINK.pll_locked   = st_ff.lock_s;

endmodule : rcs_dev

// File: rcs_host.sv
module rcs_host
  import rcs_pkg::*;
#(
  parameter int REQ_HOLD    = REQ_HOLD_CYC,
  parameter int LOCK_STABLE = LOCK_STABLE_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  rcs_link_if.host         LINK,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             OUT_ENABLE
);

  // ****************************************
  // state
  // ****************************************
  rcs_host_state_type_rec_type st_ff;
  rcs_host_state_type_rec_type nxt_st;
  logic                        acc;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    acc    = (AVS_READ || AVS_WRITE) && !st_ff.wait_r;

    // one wait cycle per access, read word latched meanwhile
    nxt_st.wait_r = !((AVS_READ || AVS_WRITE) && st_ff.wait_r);
    if ((AVS_READ || AVS_WRITE) && st_ff.wait_r) begin
      nxt_st.rdata = '0;
      if (AVS_ADDRESS == STAT_OFS) begin
        nxt_st.rdata[STAT_LOSS0]  = LINK.loss_primary;
        nxt_st.rdata[STAT_LOSS1]  = LINK.loss_backup;
        nxt_st.rdata[STAT_ACTIVE] = LINK.active_sel;
        nxt_st.rdata[STAT_BUSY]   = (st_ff.st != H_IDLE);
        nxt_st.rdata[STAT_OUT_EN] = st_ff.oen;
      end
    end

    case (st_ff.st)
      H_IDLE: begin
        // a go while busy is dropped; request must start low
        if (acc && AVS_WRITE && (AVS_ADDRESS == CTRL_OFS) && AVS_WRITEDATA[CTRL_GO_BIT]) begin
          nxt_st.req = 1'b1;                                      // see R10
          nxt_st.cnt = '0;
          nxt_st.st  = H_REQ;
        end
      end
      H_REQ: begin
        // hold long enough for the slower input plus delay
        if (st_ff.cnt >= HCNT_W'(REQ_HOLD - 1)) begin             // see R17, R18
          nxt_st.req = 1'b0;                                      // see R16
          nxt_st.rst = 1'b1;                                      // see R20
          nxt_st.oen = 1'b0;
          nxt_st.cnt = '0;
          nxt_st.st  = H_RST;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      H_RST: begin
        if (st_ff.cnt >= HCNT_W'(RESET_HOLD_CYC - 1)) begin       // see R22
          nxt_st.rst = 1'b0;
          nxt_st.cnt = '0;
          nxt_st.st  = H_LOCK;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      H_LOCK: begin
        // any drop of lock restarts the stability count
        if (!LINK.pll_locked) begin
          nxt_st.cnt = '0;
        end else if (st_ff.cnt >= HCNT_W'(LOCK_STABLE - 1)) begin // see R22
          nxt_st.oen = 1'b1;
          nxt_st.st  = H_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_st.st = H_LOCK;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= HOST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign AVS_READDATA    = st_ff.rdata;
  assign AVS_WAITREQUEST = st_ff.wait_r;
  assign OUT_ENABLE      = st_ff.oen;
  assign LINK.switch_req = st_ff.req;
  assign LINK.loop_reset = st_ff.rst;

endmodule : rcs_host

// File: rcs_chk.sv
module rcs_chk
  import rcs_pkg::*;
#(
  parameter int REQ_HOLD = REQ_HOLD_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic switch_req,
  input wire logic loop_reset,
  input wire logic loss_primary,
  input wire logic loss_backup,
  input wire logic active_sel,
  input wire logic pll_locked
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // ****************************************
  // helper counters
  // ****************************************
  int req_cnt_ff;

  // length of the current request pulse
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      req_cnt_ff <= 0;
    end else begin
      req_cnt_ff <= switch_req ? req_cnt_ff + 1 : 0;
    end
  end

  // ****************************************
  // link properties
  // ****************************************
  req_hold_a: assert property (
    $fell(switch_req) |-> req_cnt_ff == REQ_HOLD) else $error("request pulse length wrong");
  req_reset_a: assert property (
    $fell(switch_req) |-> loop_reset) else $error("no loop reset after request");
  reset_pulse_a: assert property (
    $rose(loop_reset) |=> !loop_reset) else $error("loop reset pulse too long");
  req_excl_a: assert property (
    !(switch_req && loop_reset)) else $error("request overlaps loop reset");
  to_backup_a: assert property (
    $rose(active_sel) |-> !loss_backup) else $error("switched to a stalled backup");
  to_primary_a: assert property (
    $fell(active_sel) |-> !loss_primary) else $error("switched to a stalled primary");
  both_dead_a: assert property (
    loss_primary && loss_backup |=> $stable(active_sel)) else $error("switch with both inputs dead");
  lock_first_a: assert property (
    $rose(switch_req) |-> pll_locked) else $error("request raised without lock");

  // main scenarios reached
  cover property ($rose(active_sel));
  cover property ($fell(active_sel));
  cover property (loss_primary && loss_backup);

endmodule : rcs_chk

// File: pll_ref_clock_switchover_tb.sv
module pll_ref_clock_switchover_tb
  import rcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 20;

  logic         clk      = 1'h0;
  logic         rst_n    = 1'h0;
  logic         lock     = 1'h0;
  logic         ph       = 1'h0;
  logic         ref_p    = 1'h0;
  logic         ref_b    = 1'h0;
  logic         run_p    = 1'h1;
  logic         run_b    = 1'h1;
  rcs_mode_type mode     = RCS_MANUAL;
  logic [3:0]   av_addr  = 4'h0;
  logic         av_rd    = 1'h0;
  logic         av_wr    = 1'h0;
  logic [31:0]  av_wd    = 32'h0;
  logic [31:0]  av_rdata;
  logic         av_wait;
  logic         ref_out;
  logic         out_en;
  int           failures = 0;
  int           n_checks = 0;

  // ****************************************
  // clocks and instances
  // ****************************************
  always #5 clk = ~clk;

  // two 40 ns references a quarter period apart; a stopped one holds its level
  always @(posedge clk) begin
    ph <= ~ph;
    if (run_p && ph) ref_p <= ~ref_p;
    if (run_b && !ph) ref_b <= ~ref_b;
  end

  rcs_link_if rcs_link_if_i ();

  rcs_dev rcs_dev_i (.CLOCK(clk), .RST_N(rst_n), .LINK(rcs_link_if_i.dev), .REF_CLOCK_PRIMARY(ref_p),
    .REF_CLOCK_BACKUP(ref_b), .PLL_LOCKED(lock), .MODE(mode), .REF_OUT(ref_out), .LOOP_RESET());

  rcs_host #(.REQ_HOLD(HOLD), .LOCK_STABLE(2)) rcs_host_i (.CLOCK(clk), .RST_N(rst_n),
    .LINK(rcs_link_if_i.host), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
    .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .OUT_ENABLE(out_en));

  rcs_chk #(.REQ_HOLD(HOLD)) rcs_chk_i (.CLOCK(clk), .RST_N(rst_n),
    .switch_req(rcs_link_if_i.switch_req), .loop_reset(rcs_link_if_i.loop_reset),
    .loss_primary(rcs_link_if_i.loss_primary), .loss_backup(rcs_link_if_i.loss_backup),
    .active_sel(rcs_link_if_i.active_sel), .pll_locked(rcs_link_if_i.pll_locked));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one bus access, held until waitrequest is sampled low
  task automatic av(logic wr, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    av_rd <= !wr;
    av_wr <= wr;
    av_addr <= a;
    av_wd <= d;
    n = 0;
    // waitrequest is looked at mid-cycle, where it has settled
    do begin
      @(negedge clk);
      n++;
    end while (av_wait !== 1'h0 && n < 50);
    // the access is taken at this edge; read data already stands
    @(posedge clk);
    q = av_rdata;
    av_rd <= 1'h0;
    av_wr <= 1'h0;
    if (n >= 50) failures++;
  endtask : av

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // start a switch and poll status until the host is idle, gathering loss bits
  task automatic go(output logic [1:0] seen);
    logic [31:0] q;
    int          n;
    seen = 2'h0;
    n = 0;
    av(1'h1, CTRL_OFS, 32'h1, q);
    do begin
      av(1'h0, STAT_OFS, 32'h0, q);
      seen |= q[1:0];
      n++;
    end while (q[STAT_BUSY] !== 1'h0 && n < 40);
  endtask : go

  task automatic wait_act(logic v);
    int n;
    n = 0;
    while (rcs_link_if_i.active_sel !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("active_sel", {31'h0, v}, {31'h0, rcs_link_if_i.active_sel});
  endtask : wait_act

  // mode is static, so every change goes through a reset
  task automatic restart(rcs_mode_type m);
    @(posedge clk);
    rst_n <= 1'h0;
    mode <= m;
    idle(4);
    rst_n <= 1'h1;
    idle(30);
  endtask : restart

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] q;
    restart(RCS_MANUAL);
    av(1'h0, STAT_OFS, 32'h0, q);
    chk("status unlocked", 32'h8, q);
    av(1'h1, CTRL_OFS, 32'h1, q);
    idle(2);
    chk("busy go refused", 32'h0, {31'h0, rcs_link_if_i.switch_req});
    lock <= 1'h1;
    idle(10);
    av(1'h0, STAT_OFS, 32'h0, q);
    chk("status locked", 32'h10, q);
    av(1'h0, 4'h8, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    av(1'h0, CTRL_OFS, 32'h0, q);
    chk("ctrl read", 32'h0, q);
    chk("out enable", 32'h1, {31'h0, out_en});
    $display("test reset done");
  endtask : t_reset

  task automatic t_manual();
    logic [1:0] s;
    logic       hi;
    logic       lo;
    go(s);
    wait_act(1'h1);
    hi = 1'h0;
    lo = 1'h0;
    repeat (8) begin
      @(negedge clk);
      hi |= (ref_out === 1'h1);
      lo |= (ref_out === 1'h0);
    end
    chk("ref_out toggles", 32'h1, {31'h0, hi & lo});
    chk("manual loss", 32'h0, {30'h0, s});
    idle(20);
    wait_act(1'h1);
    go(s);
    wait_act(1'h0);
    $display("test manual done");
  endtask : t_manual

  task automatic t_auto();
    logic [1:0] s;
    restart(RCS_AUTO);
    go(s);
    wait_act(1'h0);
    run_p <= 1'h0;
    idle(4);
    chk("early loss", 32'h0, {31'h0, rcs_link_if_i.loss_primary});
    wait_act(1'h1);
    chk("loss primary", 32'h1, {31'h0, rcs_link_if_i.loss_primary});
    chk("loss backup", 32'h0, {31'h0, rcs_link_if_i.loss_backup});
    run_p <= 1'h1;
    idle(20);
    run_b <= 1'h0;
    wait_act(1'h0);
    run_p <= 1'h0;
    idle(40);
    wait_act(1'h0);
    run_p <= 1'h1;
    run_b <= 1'h1;
    idle(20);
    $display("test auto done");
  endtask : t_auto

  task automatic t_override();
    logic [1:0]  s;
    logic [31:0] q;
    restart(RCS_OVERRIDE);
    go(s);
    wait_act(1'h1);
    // backup stops as the request rises: no count, auto held off
    av(1'h1, CTRL_OFS, 32'h1, q);
    run_b <= 1'h0;
    idle(16);
    wait_act(1'h1);
    wait_act(1'h0);
    idle(30);
    go(s);
    idle(10);
    wait_act(1'h0);
    run_b <= 1'h1;
    wait_act(1'h1);
    $display("test override done");
  endtask : t_override

  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    t_reset();
    t_manual();
    t_auto();
    t_override();
    conclude();
  end

  // the whole run needs well under 3000 cycles
  initial begin
    #100us;
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    conclude();
  end

endmodule : pll_ref_clock_switchover_tb
